// file: tb_tone_control_filter_select.sv
// Testbench: reset contents, lane codes, index gains, bypass.
// Assumes the host model drives the bank's register port.
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module tb_tone_control_filter_select;
  logic        clk, rst_n, b_in, t_in, rd_stb, wr_stb, rd_valid, b_act, t_act, bad, ok;
  logic [7:0]  sub;
  logic [31:0] wd, rdat, q;
  logic [11:0] b_set, t_set;
  logic [23:0] gain;
  int          n_errors = 0;
  int          comparisons = 0;
  tone_control_filter_select tone_control_filter_select_i (.CLK_I(clk), .RESET_N_I(rst_n),
    .SUBADDR_I(sub), .WR_STB_I(wr_stb), .WR_DATA_I(wd), .RD_STB_I(rd_stb),
    .BASS_INLINE_I(b_in), .TREBLE_INLINE_I(t_in), .RD_DATA_O(rdat), .RD_VALID_O(rd_valid),
    .BASS_SET_O(b_set), .TREBLE_SET_O(t_set), .BASS_GAIN_DB_O(gain), .BASS_ACTIVE_O(b_act),
    .TREBLE_ACTIVE_O(t_act), .ILLEGAL_SEL_O(bad));
  tone_host_model tone_host_model_i (.clk_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rdat),
    .subaddr_o(sub), .wr_stb_o(wr_stb), .wr_data_o(wd), .rd_stb_o(rd_stb));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    tone_host_model_i.rd(a, q, ok);
    `CHK("read valid", 1'b1, ok)
    `CHK(n, e, q)
  endtask
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    b_in  = 1'b0;
    t_in  = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd_chk("bass set", 8'hDA, 32'h01010101);
    rd_chk("bass index", 8'hDB, 32'h12121212);
    rd_chk("treble set", 8'hDC, 32'h01010101);
    rd_chk("unmapped", 8'hDD, 32'h0);
    b_in = 1'b1;
    t_in = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("reset gain", 24'h0, gain)
    // Every loading code, one to five, in all lanes at once
    for (int c = 1; c <= 5; c++) begin
      tone_host_model_i.wr(8'hDA, {4{8'(c)}});
      @(negedge clk);
      `CHK("bass lanes", {4{3'(c)}}, b_set)
      tone_host_model_i.wr(8'hDC, {4{8'(c)}});
      @(negedge clk);
      `CHK("treble lanes", {4{3'(c)}}, t_set)
    end
    // Keep, pick and illegal codes in one word, reserved bits in the next
    tone_host_model_i.wr(8'hDA, 32'h00050701);
    @(negedge clk);
    `CHK("illegal flag", 1'b1, bad)
    tone_host_model_i.wr(8'hDA, 32'h0);
    rd_chk("bass mixed", 8'hDA, 32'h05050501);
    tone_host_model_i.wr(8'hDC, 32'hF8FB0405);
    @(negedge clk);
    `CHK("reserved bits flag", 1'b0, bad)
    rd_chk("treble mixed", 8'hDC, 32'h05030405);
    // Full index range in one lane, both ends and 0x12 fixed in the others
    for (int i = 0; i <= 36; i++) begin
      tone_host_model_i.wr(8'hDB, {8'h00, 8'h24, 8'(i), 8'h12});
      @(negedge clk);
      `CHK("bass gain", {6'h12, 6'h2E, 6'(18 - i), 6'h00}, gain)
    end
    rd_chk("bass index", 8'hDB, 32'h00242412);
    b_in = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("bypass gain", 24'h0, gain)
    `CHK("bass active", 1'b0, b_act)
    `CHK("treble active", 1'b1, t_act)
    // Mid-run reset brings back the reset words
    t_in  = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk("index reset", 8'hDB, 32'h12121212);
    rd_chk("set reset", 8'hDA, 32'h01010101);
    `CHK("treble bypass", 1'b0, t_act)
    end_of_test();
  end
endmodule

// file: tone_control_filter_select.sv
// Tone control register bank: bass and treble filter-set selectors and
// bass boost/cut index, reached by subaddress from an I2C front end.
// Assumes the front end delivers whole 32-bit words with one-cycle strobes.
// Bypass controls belong to another register block and arrive as levels.
// Overview of operation
// - Tone shaping applies only once host sets bypass controls to inline.
// - Bass filter-set register 0xDA: lanes subwoofer, 6/5, 4/3, 7/2/1 high-to-low.
// - Treble filter-set register 0xDC uses the same four byte lanes.
// - Only low three bits per treble lane count; upper five bits reserved zero.
// - Bass index register 0xDB holds one index byte per lane, same order.
// - Every bass index byte resets to 0x12, meaning zero decibels.
// - Bass index 0x00 is +18 dB, one dB less per step, 0x24 is -18 dB.
`timescale 1ns/10ps
`include "tone_ctl_params.svh"
module tone_control_filter_select
  import tone_ctl_pkg::*;
#(
  parameter int LANES = `LANE_COUNT
) (
  input  wire logic                       CLK_I,            // 125 MHz clock
  input  wire logic                       RESET_N_I,        // Sync reset, low
  input  wire logic [7:0]                 SUBADDR_I,        // Register subaddress
  input  wire logic                       WR_STB_I,         // Write word pulse
  input  wire logic [31:0]                WR_DATA_I,        // Write word
  input  wire logic                       RD_STB_I,         // Read word pulse
  input  wire logic                       BASS_INLINE_I,    // Bass bypass off
  input  wire logic                       TREBLE_INLINE_I,  // Treble bypass off
  output logic [31:0]                     RD_DATA_O,        // Read word
  output logic                            RD_VALID_O,       // Read data pulse
  output logic [LANES*`SEL_WIDTH-1:0]     BASS_SET_O,       // Bass set per lane
  output logic [LANES*`SEL_WIDTH-1:0]     TREBLE_SET_O,     // Treble set per lane
  output logic [LANES*`GAIN_WIDTH-1:0]    BASS_GAIN_DB_O,   // Signed dB per lane
  output logic                            BASS_ACTIVE_O,    // Bass shaping live
  output logic                            TREBLE_ACTIVE_O,  // Treble shaping live
  output logic                            ILLEGAL_SEL_O     // Pulse: bad selector
);
  logic                          wr_bass_set;
  logic                          wr_bass_index;
  logic                          wr_treble_set;
  logic [LANES*`SEL_WIDTH-1:0]   bass_sel;
  logic [LANES*`SEL_WIDTH-1:0]   treble_sel;
  logic [LANES-1:0]              bass_bad;
  logic [LANES-1:0]              treble_bad;
  logic                          bass_bad_any;
  logic                          treble_bad_any;
  logic [31:0]                   bass_boost_cut_index;
  lane_byte_t                    subwoofer_lane_bass_index;
  lane_byte_t                    pair_six_five_bass_index;
  lane_byte_t                    pair_four_three_bass_index;
  lane_byte_t                    front_center_group_bass_index;
  logic [31:0]                   bass_set_word;
  logic [31:0]                   treble_set_word;
  logic [31:0]                   next_rd_data;
  logic [LANES*`GAIN_WIDTH-1:0]  next_gain;

  // Reset word, split into lane bytes by part-select below
  localparam logic [31:0] INDEX_RESET_WORD = `BASS_INDEX_RESET;

  // Subaddress decode of the three words; anything else is ignored.
  // Strobes are one cycle wide, so each decode fires once per transfer.
  assign wr_bass_set   = WR_STB_I && SUBADDR_I == `SUBADDR_BASS_SET;
  assign wr_bass_index = WR_STB_I && SUBADDR_I == `SUBADDR_BASS_INDEX;
  assign wr_treble_set = WR_STB_I && SUBADDR_I == `SUBADDR_TREBLE_SET;

  // One bass and one treble selector per lane; lane 3 is the subwoofer in the top byte.
  // Bass and treble share one lane module, so their code rules cannot drift.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      tone_lane_select u_bass (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .wr_i      (wr_bass_set),
        .data_i    (WR_DATA_I[g*8 +: 8]),
        .sel_o     (bass_sel[g*`SEL_WIDTH +: `SEL_WIDTH]),
        .illegal_o (bass_bad[g])
      );
      tone_lane_select u_treble (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .wr_i      (wr_treble_set),
        .data_i    (WR_DATA_I[g*8 +: 8]),
        .sel_o     (treble_sel[g*`SEL_WIDTH +: `SEL_WIDTH]),
        .illegal_o (treble_bad[g])
      );
      // Readback places the selector in the lane's low bits, reserved as zero
      assign bass_set_word[g*8 +: 8]   = {5'h00, bass_sel[g*`SEL_WIDTH +: `SEL_WIDTH]};
      assign treble_set_word[g*8 +: 8] = {5'h00, treble_sel[g*`SEL_WIDTH +: `SEL_WIDTH]};
      // Linear map: gain = 18 - index, in whole decibels; six bits cover the
      // legal range, and an index above the limit wraps to a meaningless gain
      gain_db_t lane_index; // Low six index bits
      gain_db_t lane_gain;  // Gain before bypass
      assign lane_index = bass_boost_cut_index[g*8 +: `GAIN_WIDTH];
      assign lane_gain  = `BASS_MAX_BOOST_DB - lane_index;
      // Bypass holds the gain at zero so no shaping leaks through
      assign next_gain[g*`GAIN_WIDTH +: `GAIN_WIDTH] =
        BASS_INLINE_I ? lane_gain : 6'h00;
    end
  endgenerate

  // Subwoofer index byte; values above the limit are stored as written, the
  // host is trusted not to send them and the gain then means nothing
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      subwoofer_lane_bass_index <= INDEX_RESET_WORD[31:24];
    end else if (wr_bass_index) begin
      subwoofer_lane_bass_index <= WR_DATA_I[31:24];
    end
  end

  // Index byte of the 6/5 pair
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pair_six_five_bass_index <= INDEX_RESET_WORD[23:16];
    end else if (wr_bass_index) begin
      pair_six_five_bass_index <= WR_DATA_I[23:16];
    end
  end

  // Index byte of the 4/3 pair
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      pair_four_three_bass_index <= INDEX_RESET_WORD[15:8];
    end else if (wr_bass_index) begin
      pair_four_three_bass_index <= WR_DATA_I[15:8];
    end
  end

  // Index byte of the 7/2/1 group
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      front_center_group_bass_index <= INDEX_RESET_WORD[7:0];
    end else if (wr_bass_index) begin
      front_center_group_bass_index <= WR_DATA_I[7:0];
    end
  end

  // Lanes rejoined in word order, subwoofer in the top byte
  assign bass_boost_cut_index = {subwoofer_lane_bass_index,
                                 pair_six_five_bass_index,
                                 pair_four_three_bass_index,
                                 front_center_group_bass_index};

  // Read mux; unmapped subaddresses answer zero
  always_comb begin
    case (SUBADDR_I)
      `SUBADDR_BASS_SET:   next_rd_data = bass_set_word;
      `SUBADDR_BASS_INDEX: next_rd_data = bass_boost_cut_index;
      `SUBADDR_TREBLE_SET: next_rd_data = treble_set_word;
      default:             next_rd_data = 32'h00000000;
    endcase
  end

  // Read valid, exactly one cycle after the strobe edge
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= RD_STB_I;
    end
  end

  // Read word, held until the next read so a slow host can still take it;
  // a write in the same cycle is seen by the following read only
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      RD_DATA_O <= 32'h00000000;
    end else if (RD_STB_I) begin
      RD_DATA_O <= next_rd_data;
    end
  end

  // Bass selections to the filter datapath, one cycle behind the lanes
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      BASS_SET_O <= '0;
    end else begin
      BASS_SET_O <= bass_sel;
    end
  end

  // Treble selections, same timing as bass
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TREBLE_SET_O <= '0;
    end else begin
      TREBLE_SET_O <= treble_sel;
    end
  end

  // Per-lane gain; bypass already forces zero in next_gain
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      BASS_GAIN_DB_O <= '0;
    end else begin
      BASS_GAIN_DB_O <= next_gain;
    end
  end

  // Bass shaping live flag; the datapath must gate the filter sets on it,
  // since a zero gain alone cannot say whether shaping is inline
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      BASS_ACTIVE_O <= 1'b0;
    end else begin
      BASS_ACTIVE_O <= BASS_INLINE_I;
    end
  end

  // Treble shaping live flag
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TREBLE_ACTIVE_O <= 1'b0;
    end else begin
      TREBLE_ACTIVE_O <= TREBLE_INLINE_I;
    end
  end

  // Any lane of either register written with a reserved code
  assign bass_bad_any   = |bass_bad;
  assign treble_bad_any = |treble_bad;

  // Illegal selector flag, a second stage behind the lane flags; the host
  // sees it two cycles after the bad write, the codes themselves are dropped
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ILLEGAL_SEL_O <= 1'b0;
    end else begin
      ILLEGAL_SEL_O <= bass_bad_any || treble_bad_any;
    end
  end
endmodule

// file: tone_control_filter_select_chk.sv
// Checker for the tone control bank: read timing, bypass tracking, bad codes.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/10ps
module tone_control_filter_select_chk #(
  parameter int LANES = 4
) (
  input wire logic               CLK_I,           // Clock
  input wire logic               RESET_N_I,       // Reset, low
  input wire logic [7:0]         SUBADDR_I,       // Subaddress
  input wire logic               WR_STB_I,        // Write pulse
  input wire logic [31:0]        WR_DATA_I,       // Write word
  input wire logic               RD_STB_I,        // Read pulse
  input wire logic               BASS_INLINE_I,   // Bass inline
  input wire logic               TREBLE_INLINE_I, // Treble inline
  input wire logic               RD_VALID_O,      // Read valid
  input wire logic               BASS_ACTIVE_O,   // Bass live
  input wire logic               TREBLE_ACTIVE_O, // Treble live
  input wire logic               ILLEGAL_SEL_O,   // Bad code pulse
  input wire logic [LANES*3-1:0] BASS_SET_O,      // Bass sets
  input wire logic [LANES*6-1:0] BASS_GAIN_DB_O   // Bass gains
);
  // Set write with code 6 or 7 in any lane; upper lane bits do not count
  wire logic set_wr = WR_STB_I && (SUBADDR_I == 8'hDA || SUBADDR_I == 8'hDC);
  wire logic bad = &WR_DATA_I[26:25] | &WR_DATA_I[18:17] | &WR_DATA_I[10:9] | &WR_DATA_I[2:1];
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_read_lat: assert property (RD_STB_I |=> RD_VALID_O)
    else $error("read not answered");
  a_read_cause: assert property (RD_VALID_O |-> $past(RD_STB_I))
    else $error("read valid without strobe");
  a_bass_track: assert property (1'b1 |=> BASS_ACTIVE_O == $past(BASS_INLINE_I))
    else $error("bass active wrong");
  a_treble_track: assert property (1'b1 |=> TREBLE_ACTIVE_O == $past(TREBLE_INLINE_I))
    else $error("treble active wrong");
  a_gain_bypass: assert property ((!BASS_INLINE_I) [*3] |-> BASS_GAIN_DB_O == '0)
    else $error("gain live in bypass");
  a_bad_flag: assert property (set_wr && bad |-> ##2 ILLEGAL_SEL_O)
    else $error("bad code not flagged");
  a_bad_cause: assert property (ILLEGAL_SEL_O |-> $past(set_wr && bad, 2))
    else $error("bad flag without cause");
  a_zero_keeps: assert property (WR_STB_I && SUBADDR_I == 8'hDA && WR_DATA_I == '0 |-> ##2 $stable(BASS_SET_O))
    else $error("zero write changed sets");
endmodule
bind tone_control_filter_select tone_control_filter_select_chk #(.LANES(LANES)) chk_i (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SUBADDR_I(SUBADDR_I), .WR_STB_I(WR_STB_I),
  .WR_DATA_I(WR_DATA_I), .RD_STB_I(RD_STB_I), .BASS_INLINE_I(BASS_INLINE_I),
  .TREBLE_INLINE_I(TREBLE_INLINE_I), .RD_VALID_O(RD_VALID_O), .BASS_ACTIVE_O(BASS_ACTIVE_O),
  .TREBLE_ACTIVE_O(TREBLE_ACTIVE_O), .ILLEGAL_SEL_O(ILLEGAL_SEL_O), .BASS_SET_O(BASS_SET_O),
  .BASS_GAIN_DB_O(BASS_GAIN_DB_O));

// file: tone_ctl_params.svh
// Subaddresses, field positions, reset values and limits for the tone
// control register bank. Definitions only; included by both design files.
`ifndef TONE_CTL_PARAMS_SVH
`define TONE_CTL_PARAMS_SVH

`define SUBADDR_BASS_SET      8'hDA
`define SUBADDR_BASS_INDEX    8'hDB
`define SUBADDR_TREBLE_SET    8'hDC

`define LANE_COUNT            4
`define LANE_BYTE_WIDTH       8
`define SEL_WIDTH             3
`define SEL_NO_CHANGE         3'h0
`define SEL_MAX_LEGAL         3'h5
`define SEL_RESET             3'h1

`define BASS_INDEX_RESET      32'h12121212
`define BASS_INDEX_MAX        8'h24
`define BASS_MAX_BOOST_DB     6'h12
`define GAIN_WIDTH            6

`endif

// file: tone_ctl_pkg.sv
// Types shared by the tone control register bank and its lane selector.
// Constants live in tone_ctl_params.svh.
package tone_ctl_pkg;
  typedef logic [2:0] filter_sel_t;
  typedef logic [7:0] lane_byte_t;
  typedef logic [5:0] gain_db_t;
endpackage

// file: tone_host_model.sv
// Host model: subaddress writes and reads as one-cycle strobes.
// Assumes the bank answers a read one cycle after the strobe.
`timescale 1ns/10ps
module tone_host_model (
  input  wire logic        clk_i,      // Clock
  input  wire logic        rd_valid_i, // Read valid
  input  wire logic [31:0] rd_data_i,  // Read word
  output logic [7:0]       subaddr_o,  // Subaddress
  output logic             wr_stb_o,   // Write pulse
  output logic [31:0]      wr_data_o,  // Write word
  output logic             rd_stb_o    // Read pulse
);
  initial begin
    subaddr_o = 8'h00;
    wr_stb_o  = 1'b0;
    wr_data_o = 32'h0;
    rd_stb_o  = 1'b0;
  end
  // Idle lines get the inverse, so a stale word never passes for fresh
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_i);
    subaddr_o = a;
    wr_data_o = d; // Callers keep index bytes in range
    wr_stb_o  = 1'b1;
    @(negedge clk_i);
    wr_stb_o  = 1'b0;
    subaddr_o = ~a;
    wr_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(negedge clk_i);
    subaddr_o = a;
    rd_stb_o  = 1'b1;
    @(negedge clk_i);
    rd_stb_o  = 1'b0;
    subaddr_o = ~a;
    ok        = rd_valid_i;
    d         = rd_data_i;
  endtask
endmodule

// file: tone_lane_select.sv
// One lane of a filter-set register: holds a 3-bit selector.
// Assumes the caller presents one byte and a one-cycle write strobe.
`timescale 1ns/10ps
`include "tone_ctl_params.svh"
module tone_lane_select
  import tone_ctl_pkg::*;
#(
  parameter filter_sel_t RESET_SEL = `SEL_RESET
) (
  input  wire logic        clk_i,     // System clock
  input  wire logic        reset_n_i, // Synchronous reset, active low
  input  wire logic        wr_i,      // Write strobe for this register
  input  wire lane_byte_t  data_i,    // Lane byte as written
  output filter_sel_t      sel_o,     // Current filter-set selection
  output logic             illegal_o  // Pulse: reserved code written
);
  filter_sel_t code;

  // Only the low bits select; reserved upper bits are ignored
  assign code = data_i[`SEL_WIDTH-1:0];

  // Zero keeps, one to five load, six and seven are dropped
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sel_o <= RESET_SEL;
    end else if (wr_i && code != `SEL_NO_CHANGE && code <= `SEL_MAX_LEGAL) begin
      sel_o <= code;
    end
  end

  // Flag illegal codes so the host slip is visible rather than silent
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= wr_i && code > `SEL_MAX_LEGAL;
    end
  end
endmodule
